// ==== rtl/hpf_pkg.sv ====
package hpf_pkg;

  // Bus geometry
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;

  // Register and FIFO port word indices
  localparam logic [ADDR_W-1:0] A_TX_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] A_RX_DATA = 4'h1;
  localparam logic [ADDR_W-1:0] A_RX_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] A_TX_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] A_TX_CFG  = 4'h4;
  localparam logic [ADDR_W-1:0] A_RX_CFG  = 4'h5;
  localparam logic [ADDR_W-1:0] A_RX_DP   = 4'h6;
  localparam logic [ADDR_W-1:0] A_INTERRUPT_STATUS_REG = 4'h7;
  localparam logic [ADDR_W-1:0] A_RX_INF  = 4'h8;

  // Transmit command word fields
  localparam int CA_LEN_LSB = 0;
  localparam int CA_LEN_W   = 11;
  localparam int CA_LAST    = 12;
  localparam int CA_FIRST   = 13;
  localparam int CA_OFF_LSB = 16;
  localparam int CA_ALN_LSB = 24;
  localparam int CB_LEN_LSB = 0;

  // Control and status bit positions
  localparam int TXC_ON      = 0;
  localparam int TXC_STOP    = 1;
  localparam int TXC_DISCARD = 2;
  localparam int RXC_OFF_LSB = 0;
  localparam int RXC_PAD_LSB = 8;
  localparam int RXC_DUMP    = 15;
  localparam int DP_SKIP     = 31;
  localparam int IS_TX_ERR   = 0;
  localparam int IS_RX_ERR   = 1;
  localparam int IS_TX_STOP  = 2;
  localparam int IS_SRST     = 31;
  localparam int RS_LEN_LSB  = 16;
  localparam int RS_LEN_W    = 14;
  localparam int INF_STAT_LSB = 16;

  // Reset values
  localparam logic [4:0] RX_OFF_RST = 5'h00;
  localparam logic [1:0] RX_PAD_RST = 2'h0;

  // Least head-packet size for a fast-forward, in words
  localparam int SKIP_MIN_WORDS = 4;

  typedef enum logic [1:0] {TX_CMD_A, TX_CMD_B, TX_DATA} hpf_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_LEAD, RX_BODY, RX_TAIL, RX_PAD, RX_STAT} hpf_rx_st_t;

  // Buffer span rounded up to its end alignment (4, 16 or 32 bytes)
  function automatic logic [11:0] hpf_round_up(input logic [11:0] span, input logic [1:0] sel);
    logic [11:0] m;
    m = (sel == 2'h0) ? 12'h003 : (sel == 2'h1) ? 12'h00f : 12'h01f;
    return (span + m) & ~m;
  endfunction

  // Word built from the current input word shifted up by b bytes
  function automatic logic [31:0] hpf_shift(input logic [31:0] cur, input logic [31:0] prev,
                                            input logic [1:0] b);
    logic [63:0] both;
    both = {cur, prev} >> (6'h20 - {1'b0, b, 3'h0});
    return both[31:0];
  endfunction

  // Burst padding mask in words: none, 4, 8 or 16
  function automatic logic [3:0] hpf_pad_mask(input logic [1:0] sel);
    return (sel == 2'h0) ? 4'h0 : (sel == 2'h1) ? 4'h3 : (sel == 2'h2) ? 4'h7 : 4'hf;
  endfunction

endpackage

// ==== rtl/hpf_host_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface hpf_host_if;
  logic [hpf_pkg::ADDR_W-1:0] addr;
  logic [hpf_pkg::WORD_W-1:0] wdata;
  logic                       wr;
  logic                       rd;
  logic [hpf_pkg::WORD_W-1:0] rdata;
  logic                       rx_mid_pkt;
  logic                       rx_skip_busy;
  logic [15:0]                rx_data_words;
  logic [7:0]                 rx_stat_words;

  modport dev (input addr, wdata, wr, rd,
               output rdata, rx_mid_pkt, rx_skip_busy, rx_data_words, rx_stat_words);
  modport host (output addr, wdata, wr, rd,
                input rdata, rx_mid_pkt, rx_skip_busy, rx_data_words, rx_stat_words);
endinterface
`default_nettype wire

// ==== rtl/hpf_device.sv ====
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - every command A goes into TX FIFO
// - command B stored only on first segment
// - whole-word start offset dropped, bytes kept
// - whole-word end padding dropped, bytes kept
// - transmit errors never halt the transmitter
// - length mismatch or FIFO overrun flags error
// - host gives matching B; mismatch flags error
// - status overrun flags error unless discard set
// - stop waits for frame in progress
// - final status clears stop, on; sets sticky stopped flag
// - setting on again resumes queued frames
// - data first, status last, separate FIFOs
// - status readable ahead of its data
// - underrun raises receive error; soft reset recovers
// - start shifted by 0-31 byte offset
// - host changes offset only between packets
// - optional burst padding; host uses length
// - offset and padding applied per packet
// - skip bit discards head packet, receiver runs
// - host skips only packets of four-plus words
// - no data reads while skipping; status untouched
// - dump resets RX pointers, bit self-clears
// - discard mode transmits with status FIFO full
module hpf_device #(
  parameter int TX_DEPTH   = 512,
  parameter int RX_DEPTH   = 512,
  parameter int STAT_DEPTH = 16
) (
  // Clock, reset, enable
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       ce_i,
  // Host register and FIFO port
  hpf_host_if.dev                         bus,
  // Transmit stream toward the MAC
  output logic [hpf_pkg::WORD_W-1:0]      tx_word_o,
  output logic                            tx_valid_o,
  input  wire logic                       tx_ready_i,
  input  wire logic [hpf_pkg::WORD_W-1:0] tx_stat_i,
  input  wire logic                       tx_stat_valid_i,
  // Receive stream from the MAC
  input  wire logic [hpf_pkg::WORD_W-1:0] rx_word_i,
  input  wire logic                       rx_valid_i,
  input  wire logic                       rx_last_i,
  input  wire logic [hpf_pkg::WORD_W-1:0] rx_stat_i,
  output logic                            rx_ready_o
);
  import hpf_pkg::*;

  localparam int TXA = $clog2(TX_DEPTH);
  localparam int RXA = $clog2(RX_DEPTH);
  localparam int STA = $clog2(STAT_DEPTH);

  if ((1 << TXA) != TX_DEPTH || (1 << RXA) != RX_DEPTH || (1 << STA) != STAT_DEPTH
      || STAT_DEPTH < 2 || STAT_DEPTH > 128 || RX_DEPTH > 32768 || TX_DEPTH < 8) begin : g_bad
    $error("hpf_device: depths must be powers of two within range");
  end

  logic [WORD_W:0]   tx_mem  [TX_DEPTH];
  logic [WORD_W-1:0] rx_mem  [RX_DEPTH];
  logic              rx_end  [RX_DEPTH];
  logic [WORD_W-1:0] txs_mem [STAT_DEPTH];
  logic [WORD_W-1:0] rxs_mem [STAT_DEPTH];

  logic [TXA:0] tx_wp_q, tx_rp_q, tx_cnt;
  logic [RXA:0] rx_wp_q, rx_rp_q, rx_cnt;
  logic [STA:0] txs_wp_q, txs_rp_q, txs_cnt, rxs_wp_q, rxs_rp_q, rxs_cnt;
  logic         tx_on_q, stop_q, discard_q, dump_q, skip_q, rx_mid_q;
  logic         txerr_q, rxerr_q, txstop_q;
  logic [4:0]   rx_off_q;
  logic [1:0]   rx_pad_q;

  assign tx_cnt  = tx_wp_q - tx_rp_q;
  assign rx_cnt  = rx_wp_q - rx_rp_q;
  assign txs_cnt = txs_wp_q - txs_rp_q;
  assign rxs_cnt = rxs_wp_q - rxs_rp_q;

  logic tx_full, tx_empty, rx_full, rx_empty, txs_full, txs_empty, rxs_full, rxs_empty;
  assign tx_full   = tx_cnt[TXA];
  assign tx_empty  = (tx_cnt == '0);
  assign rx_full   = rx_cnt[RXA];
  assign rx_empty  = (rx_cnt == '0);
  assign txs_full  = txs_cnt[STA];
  assign txs_empty = (txs_cnt == '0);
  assign rxs_full  = rxs_cnt[STA];
  assign rxs_empty = (rxs_cnt == '0);

  // Host strobes
  logic wr_tx, rd_rxd, rd_rxs, rd_txs, srst;
  assign wr_tx  = bus.wr && bus.addr == A_TX_DATA;
  assign rd_rxd = bus.rd && bus.addr == A_RX_DATA;
  assign rd_rxs = bus.rd && bus.addr == A_RX_STAT;
  assign rd_txs = bus.rd && bus.addr == A_TX_STAT;
  assign srst   = bus.wr && bus.addr == A_INTERRUPT_STATUS_REG && bus.wdata[IS_SRST];

  // ---------------- Transmit ingest ----------------
  hpf_tx_st_t  tx_st_q;
  logic        first_q, last_q;
  logic [9:0]  lead_q, keep_q, total_q, idx_q;
  logic [11:0] bytes_q;
  logic [WORD_W-1:0] b_ref_q;
  logic [4:0]  a_off;
  logic [10:0] a_len, b_len;
  logic [11:0] a_span;
  logic [9:0]  a_lead, a_keep, a_total;
  logic        tx_push, tx_push_end, b_bad, len_bad, tx_wr;

  always_comb begin
    a_off   = bus.wdata[CA_OFF_LSB +: 5];
    a_len   = bus.wdata[CA_LEN_LSB +: CA_LEN_W];
    a_span  = {1'b0, a_len} + {7'h00, a_off};
    a_lead  = {7'h00, a_off[4:2]};
    a_keep  = 10'((a_span + 12'h003) >> 2) - a_lead;
    a_total = 10'(hpf_round_up(a_span, bus.wdata[CA_ALN_LSB +: 2]) >> 2);
    b_len   = (tx_st_q == TX_CMD_B && first_q) ? bus.wdata[CB_LEN_LSB +: CA_LEN_W] : b_ref_q[CB_LEN_LSB +: CA_LEN_W];
    tx_push = 1'b0;
    tx_push_end = 1'b0;
    b_bad   = 1'b0;
    len_bad = 1'b0;
    if (wr_tx) begin
      unique case (tx_st_q)
        TX_CMD_A: tx_push = 1'b1;
        TX_CMD_B: begin
          tx_push = first_q;
          b_bad   = !first_q && bus.wdata != b_ref_q;
          len_bad = total_q == '0 && last_q && bytes_q != {1'b0, b_len};
        end
        TX_DATA: begin
          tx_push     = idx_q >= lead_q && idx_q < lead_q + keep_q;
          tx_push_end = last_q && idx_q == lead_q + keep_q - 10'h001;
          len_bad     = last_q && idx_q == total_q - 10'h001 && bytes_q != {1'b0, b_len};
        end
      endcase
    end
    tx_wr = tx_push && !tx_full;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_st_q <= TX_CMD_A;
      {first_q, last_q} <= 2'b00;
      {lead_q, keep_q, total_q, idx_q} <= '0;
      bytes_q <= '0;
      b_ref_q <= '0;
    end else if (ce_i) begin
      if (srst) begin
        tx_st_q <= TX_CMD_A;
      end else if (wr_tx) begin
        unique case (tx_st_q)
          TX_CMD_A: begin
            first_q <= bus.wdata[CA_FIRST];
            last_q  <= bus.wdata[CA_LAST];
            lead_q  <= a_lead;
            keep_q  <= a_keep;
            total_q <= a_total;
            bytes_q <= bus.wdata[CA_FIRST] ? {1'b0, a_len} : bytes_q + {1'b0, a_len};
            tx_st_q <= TX_CMD_B;
          end
          TX_CMD_B: begin
            if (first_q) b_ref_q <= bus.wdata;
            idx_q   <= '0;
            tx_st_q <= (total_q == '0) ? TX_CMD_A : TX_DATA;
          end
          TX_DATA: begin
            idx_q <= idx_q + 10'h001;
            if (idx_q == total_q - 10'h001) tx_st_q <= TX_CMD_A;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce_i && tx_wr) tx_mem[tx_wp_q[TXA-1:0]] <= {tx_push_end, bus.wdata};
  end

  // ---------------- Transmit egress ----------------
  logic [WORD_W:0] tx_head;
  logic            tx_can, tx_pop, mid_q, halt, txs_wr, txs_ovr;
  logic [3:0]      pend_q;
  assign tx_head = tx_mem[tx_rp_q[TXA-1:0]];
  assign tx_can  = !tx_empty && tx_on_q && (!stop_q || mid_q) && (!txs_full || discard_q);
  assign tx_pop  = tx_can && (!tx_valid_o || tx_ready_i);
  assign halt    = stop_q && !mid_q && pend_q == 4'h0 && !tx_valid_o;
  assign txs_wr  = tx_stat_valid_i && !txs_full;
  assign txs_ovr = tx_stat_valid_i && txs_full && !discard_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_word_o  <= '0;
      tx_valid_o <= 1'b0;
      mid_q      <= 1'b0;
      pend_q     <= 4'h0;
      tx_wp_q    <= '0;
      tx_rp_q    <= '0;
    end else if (ce_i) begin
      if (srst) begin
        tx_valid_o <= 1'b0;
        mid_q      <= 1'b0;
        pend_q     <= 4'h0;
        tx_wp_q    <= '0;
        tx_rp_q    <= '0;
      end else begin
        if (tx_wr) tx_wp_q <= tx_wp_q + 1'b1;
        if (tx_pop) begin
          tx_word_o  <= tx_head[WORD_W-1:0];
          tx_valid_o <= 1'b1;
          mid_q      <= !tx_head[WORD_W];
          tx_rp_q    <= tx_rp_q + 1'b1;
        end else if (tx_ready_i) begin
          tx_valid_o <= 1'b0;
        end
        pend_q <= pend_q + {3'h0, tx_pop && tx_head[WORD_W]} - {3'h0, tx_stat_valid_i && pend_q != 4'h0};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      txs_wp_q <= '0;
      txs_rp_q <= '0;
    end else if (ce_i) begin
      if (srst) begin
        txs_wp_q <= '0;
        txs_rp_q <= '0;
      end else begin
        if (txs_wr) txs_wp_q <= txs_wp_q + 1'b1;
        if (rd_txs && !txs_empty) txs_rp_q <= txs_rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce_i && txs_wr) txs_mem[txs_wp_q[STA-1:0]] <= tx_stat_i;
  end

  // ---------------- Receive ingest ----------------
  hpf_rx_st_t  rx_st_q;
  logic [2:0]  rx_lead_q;
  logic [1:0]  rx_b_q, rx_psel_q;
  logic [3:0]  rx_pcnt_q;
  logic [WORD_W-1:0] carry_q, rx_stat_q, rx_wword;
  logic [15:0] r_len;
  logic        rx_wr, rxs_wr, pad_done, extra;

  assign r_len    = {2'b00, rx_stat_i[RS_LEN_LSB +: RS_LEN_W]};
  assign extra    = ((r_len + {14'h0000, rx_b_q} + 16'h0003) >> 2) != ((r_len + 16'h0003) >> 2);
  assign pad_done = (rx_pcnt_q & hpf_pad_mask(rx_psel_q)) == 4'h0;
  assign rxs_wr   = rx_st_q == RX_STAT && !rxs_full;
  assign rx_ready_o = rx_st_q == RX_BODY && !rx_full;

  always_comb begin
    rx_wr    = 1'b0;
    rx_wword = '0;
    unique case (rx_st_q)
      RX_LEAD: rx_wr = !rx_full;
      RX_BODY: begin
        rx_wr    = rx_valid_i && !rx_full;
        rx_wword = hpf_shift(rx_word_i, carry_q, rx_b_q);
      end
      RX_TAIL: begin
        rx_wr    = !rx_full;
        rx_wword = hpf_shift('0, carry_q, rx_b_q);
      end
      RX_PAD:  rx_wr = !rx_full && !pad_done;
      default: rx_wr = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_st_q   <= RX_IDLE;
      rx_lead_q <= 3'h0;
      rx_b_q    <= 2'h0;
      rx_psel_q <= 2'h0;
      rx_pcnt_q <= 4'h0;
      carry_q   <= '0;
      rx_stat_q <= '0;
    end else if (ce_i) begin
      if (srst) begin
        rx_st_q <= RX_IDLE;
      end else begin
        if (rx_wr) rx_pcnt_q <= rx_pcnt_q + 4'h1;
        unique case (rx_st_q)
          RX_IDLE: if (rx_valid_i) begin
            rx_lead_q <= rx_off_q[4:2];
            rx_b_q    <= rx_off_q[1:0];
            rx_psel_q <= rx_pad_q;
            rx_pcnt_q <= 4'h0;
            carry_q   <= '0;
            rx_st_q   <= (rx_off_q[4:2] != 3'h0) ? RX_LEAD : RX_BODY;
          end
          RX_LEAD: if (rx_wr) begin
            rx_lead_q <= rx_lead_q - 3'h1;
            if (rx_lead_q == 3'h1) rx_st_q <= RX_BODY;
          end
          RX_BODY: if (rx_wr) begin
            carry_q <= rx_word_i;
            if (rx_last_i) begin
              rx_stat_q <= rx_stat_i;
              rx_st_q   <= extra ? RX_TAIL : RX_PAD;
            end
          end
          RX_TAIL: if (rx_wr) rx_st_q <= RX_PAD;
          RX_PAD:  if (pad_done) rx_st_q <= RX_STAT;
          RX_STAT: if (rxs_wr) rx_st_q <= RX_IDLE;
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      if (rx_wr) begin
        rx_mem[rx_wp_q[RXA-1:0]] <= rx_wword;
        rx_end[rx_wp_q[RXA-1:0]] <= 1'b0;
      end
      if (rxs_wr) begin
        rx_end[rx_wp_q[RXA-1:0] - 1'b1]   <= 1'b1;
        rxs_mem[rxs_wp_q[STA-1:0]] <= rx_stat_q;
      end
    end
  end

  // ---------------- Receive egress ----------------
  logic rx_head_end, skip_pop, rxd_pop, rx_under;
  assign rx_head_end = rx_end[rx_rp_q[RXA-1:0]];
  assign skip_pop = skip_q && !rx_empty && !rd_rxd;
  assign rxd_pop  = (rd_rxd && !rx_empty) || skip_pop;
  assign rx_under = (rd_rxd && rx_empty) || (rd_rxs && rxs_empty);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rxs_wp_q <= '0;
      rxs_rp_q <= '0;
      rx_mid_q <= 1'b0;
    end else if (ce_i) begin
      if (srst || dump_q) begin
        rx_wp_q  <= '0;
        rx_rp_q  <= '0;
        rxs_wp_q <= '0;
        rxs_rp_q <= '0;
        rx_mid_q <= 1'b0;
      end else begin
        if (rx_wr) rx_wp_q <= rx_wp_q + 1'b1;
        if (rxd_pop) begin
          rx_rp_q  <= rx_rp_q + 1'b1;
          rx_mid_q <= !rx_head_end;
        end
        if (rxs_wr) rxs_wp_q <= rxs_wp_q + 1'b1;
        if (rd_rxs && !rxs_empty) rxs_rp_q <= rxs_rp_q + 1'b1;
      end
    end
  end

  // ---------------- Control and status registers ----------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {tx_on_q, stop_q, discard_q} <= 3'b000;
    end else if (ce_i) begin
      if (srst) begin
        {tx_on_q, stop_q, discard_q} <= 3'b000;
      end else if (bus.wr && bus.addr == A_TX_CFG) begin
        tx_on_q   <= bus.wdata[TXC_ON];
        stop_q    <= bus.wdata[TXC_STOP];
        discard_q <= bus.wdata[TXC_DISCARD];
      end else if (halt) begin
        tx_on_q <= 1'b0;
        stop_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_off_q <= RX_OFF_RST;
      rx_pad_q <= RX_PAD_RST;
      dump_q   <= 1'b0;
      skip_q   <= 1'b0;
    end else if (ce_i) begin
      if (bus.wr && bus.addr == A_RX_CFG && !srst) begin
        rx_off_q <= bus.wdata[RXC_OFF_LSB +: 5];
        rx_pad_q <= bus.wdata[RXC_PAD_LSB +: 2];
        dump_q   <= bus.wdata[RXC_DUMP];
      end else begin
        dump_q <= 1'b0;
      end
      if (bus.wr && bus.addr == A_RX_DP && bus.wdata[DP_SKIP]) skip_q <= 1'b1;
      else if (srst || dump_q || (skip_pop && rx_head_end)) skip_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {txerr_q, rxerr_q, txstop_q} <= 3'b000;
    end else if (ce_i) begin
      if (srst) begin
        {txerr_q, rxerr_q, txstop_q} <= 3'b000;
      end else begin
        txerr_q  <= (txerr_q && !(bus.wr && bus.addr == A_INTERRUPT_STATUS_REG && bus.wdata[IS_TX_ERR]))
                    || (tx_push && tx_full) || b_bad || len_bad || txs_ovr;
        rxerr_q  <= (rxerr_q && !(bus.wr && bus.addr == A_INTERRUPT_STATUS_REG && bus.wdata[IS_RX_ERR])) || rx_under;
        txstop_q <= (txstop_q && !(bus.wr && bus.addr == A_INTERRUPT_STATUS_REG && bus.wdata[IS_TX_STOP]))
                    || (halt && !(bus.wr && bus.addr == A_TX_CFG));
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.rdata <= '0;
    end else if (ce_i) begin
      bus.rdata <= '0;
      if (bus.rd) begin
        unique case (bus.addr)
          A_RX_DATA: if (!rx_empty) bus.rdata <= rx_mem[rx_rp_q[RXA-1:0]];
          A_RX_STAT: if (!rxs_empty) bus.rdata <= rxs_mem[rxs_rp_q[STA-1:0]];
          A_TX_STAT: if (!txs_empty) bus.rdata <= txs_mem[txs_rp_q[STA-1:0]];
          A_TX_CFG:  bus.rdata <= {29'h0, discard_q, stop_q, tx_on_q};
          A_RX_CFG:  bus.rdata <= {16'h0, dump_q, 5'h00, rx_pad_q, 3'h0, rx_off_q};
          A_RX_DP:   bus.rdata <= {skip_q, 31'h0};
          A_INTERRUPT_STATUS_REG: bus.rdata <= {29'h0, txstop_q, rxerr_q, txerr_q};
          A_RX_INF:  bus.rdata <= {8'h00, 8'(rxs_cnt), 16'(rx_cnt)};
          default:   bus.rdata <= '0;
        endcase
      end
    end
  end

  assign bus.rx_mid_pkt    = rx_mid_q;
  assign bus.rx_skip_busy  = skip_q;
  assign bus.rx_data_words = 16'(rx_cnt);
  assign bus.rx_stat_words = 8'(rxs_cnt);

endmodule // hpf_device
`default_nettype wire

// ==== rtl/hpf_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpf_host (
  // Clock, reset, enable
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       ce_i,
  // Software port
  input  wire logic [hpf_pkg::ADDR_W-1:0] sw_addr_i,
  input  wire logic [hpf_pkg::WORD_W-1:0] sw_wdata_i,
  input  wire logic                       sw_wr_i,
  input  wire logic                       sw_rd_i,
  output logic [hpf_pkg::WORD_W-1:0]      sw_rdata_o,
  output logic                            sw_refused_o,
  // Device side
  hpf_host_if.host                        bus
);
  import hpf_pkg::*;

  logic rd_ok, wr_ok, refuse, refused_q;

  always_comb begin
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    // no data reads while skipping or empty
    if (sw_addr_i == A_RX_DATA) rd_ok = !bus.rx_skip_busy && bus.rx_data_words != 16'h0000;
    if (sw_addr_i == A_RX_STAT) rd_ok = bus.rx_stat_words != 8'h00;
    if (sw_addr_i == A_RX_CFG) wr_ok = !bus.rx_mid_pkt;
    if (sw_addr_i == A_RX_DP && sw_wdata_i[DP_SKIP])
      wr_ok = !bus.rx_mid_pkt && bus.rx_data_words >= 16'(SKIP_MIN_WORDS);
    refuse = (sw_rd_i && !rd_ok) || (sw_wr_i && !wr_ok);
  end

  assign bus.addr  = sw_addr_i;
  assign bus.wdata = sw_wdata_i;
  assign bus.wr    = sw_wr_i && wr_ok;
  assign bus.rd    = sw_rd_i && rd_ok;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refused_q <= 1'b0;
    end else if (ce_i) begin
      refused_q <= sw_rd_i && !rd_ok;
    end
  end

  assign sw_rdata_o   = refused_q ? '0 : bus.rdata;
  assign sw_refused_o = refuse;

endmodule // hpf_host
`default_nettype wire

// ==== verif/hpf_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpf_monitor (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  // Host interface
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        rx_mid_pkt,
  input wire logic        rx_skip_busy,
  input wire logic [15:0] rx_data_words,
  input wire logic [7:0]  rx_stat_words
);
  import hpf_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  skip_read_a: assert property (rx_skip_busy |-> !(rd && addr == A_RX_DATA)) else $error("skip read");
  stat_kept_a: assert property (rx_skip_busy && !rd |=> rx_stat_words >= $past(rx_stat_words))
    else $error("status lost");
  skip_end_a: assert property ($rose(rx_skip_busy) |-> ##[1:600] !rx_skip_busy) else $error("skip stuck");
  skip_ok_a: assert property (wr && addr == A_RX_DP && wdata[DP_SKIP] |-> rx_data_words >= 16'h4 && !rx_mid_pkt)
    else $error("bad skip");
  cfg_hold_a: assert property (rx_mid_pkt |-> !(wr && addr == A_RX_CFG)) else $error("cfg mid packet");
  stat_under_a: assert property (rd && addr == A_RX_STAT |-> rx_stat_words != 8'h0) else $error("stat under");
  data_under_a: assert property (rd && addr == A_RX_DATA |-> rx_data_words != 16'h0) else $error("data under");
  dump_a: assert property (wr && addr == A_RX_CFG && wdata[RXC_DUMP] |=> ##1 rx_data_words == 16'h0
    && rx_stat_words == 8'h0) else $error("dump left data");
  skip_c: cover property ($fell(rx_skip_busy));
  dump_c: cover property (wr && addr == A_RX_CFG && wdata[RXC_DUMP]);
  stat_c: cover property (rd && addr == A_RX_STAT);
endmodule // hpf_monitor
`default_nettype wire

// ==== verif/host_packet_fifo_datapath_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_packet_fifo_datapath_bench;
  import hpf_pkg::*;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, sw_wr_i = 1'b0, sw_rd_i = 1'b0, sw_refused_o, tx_valid_o, rx_ready_o;
  logic tx_ready_i = 1'b0, tx_stat_valid_i = 1'b0, rx_valid_i = 1'b0, rx_last_i = 1'b0, refused;
  logic [3:0] sw_addr_i = 4'h0;
  logic [31:0] sw_wdata_i = 32'h0, tx_stat_i = 32'h0, rx_word_i = 32'h0, rx_stat_i = 32'h0, sw_rdata_o, tx_word_o;
  logic [31:0] seed = 32'h07285f28, rs = 32'h07285f28, q, tx_last, wd [4], pq [$];
  int bad_count = 0, checks = 0, tx_n = 0, n, k, lead, pad;
  hpf_host_if bus ();
  hpf_host hpf_host_i (.sys_clk_i, .rst_b_i, .ce_i(1'b1), .sw_addr_i, .sw_wdata_i, .sw_wr_i, .sw_rd_i,
    .sw_rdata_o, .sw_refused_o, .bus);
  hpf_device #(.TX_DEPTH(16), .RX_DEPTH(32), .STAT_DEPTH(4)) hpf_device_i (.sys_clk_i, .rst_b_i, .ce_i(1'b1),
    .bus, .tx_word_o, .tx_valid_o, .tx_ready_i, .tx_stat_i, .tx_stat_valid_i, .rx_word_i, .rx_valid_i,
    .rx_last_i, .rx_stat_i, .rx_ready_o);
  hpf_monitor hpf_monitor_i (.sys_clk_i, .rst_b_i, .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
    .rx_mid_pkt(bus.rx_mid_pkt), .rx_skip_busy(bus.rx_skip_busy), .rx_data_words(bus.rx_data_words),
    .rx_stat_words(bus.rx_stat_words));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Words a packet occupies after lead words and burst padding
  function automatic int span(input int l, input int w, input int p);
    int m = (p == 0) ? 0 : (2 << p) - 1;
    return (l + w + m) & ~m;
  endfunction
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  // Random stalls of the transmit sink
  always @(posedge sys_clk_i) begin
    rs <= xs(rs);
    tx_ready_i <= rs[9];
    if (tx_valid_o && tx_ready_i) begin
      tx_n <= tx_n + 1;
      tx_last <= tx_word_o;
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic lim();
    if (k >= 200) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= w;
    sw_rd_i <= !w;
    #1 refused = sw_refused_o;
    @(posedge sys_clk_i);
    sw_wr_i <= 1'b0;
    sw_rd_i <= 1'b0;
    #1 q = sw_rdata_o;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic pkt(input int w);
    @(posedge sys_clk_i);
    for (int i = 0; i < w; i++) begin
      seed = xs(seed);
      pq.push_back(seed);
      rx_word_i <= seed;
      rx_valid_i <= 1'b1;
      rx_last_i <= (i == w - 1);
      rx_stat_i <= {2'b00, 14'(w * 4), 16'h0};
      k = 0;
      do @(posedge sys_clk_i); while (!rx_ready_o && ++k < 200);
      lim();
    end
    rx_valid_i <= 1'b0;
    // Let tail padding and the status word land
    repeat (16) @(posedge sys_clk_i);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      seed = xs(seed);
      n = 1 + int'(seed[1:0]);
      lead = 2 - 2 * c;
      pad = 2 * c;
      acc(1'b1, A_RX_CFG, 32'((pad << 8) | (lead * 4)));
      pkt(n);
      pkt(n);
      rc(A_RX_INF, {8'h0, 8'h2, 16'(2 * span(lead, n, pad))});
      rc(A_RX_STAT, {2'b00, 14'(n * 4), 16'h0});
      rc(A_RX_STAT, {2'b00, 14'(n * 4), 16'h0});
      repeat (2) for (int j = 0; j < span(lead, n, pad); j++)
        rc(A_RX_DATA, (j >= lead && j < lead + n) ? pq.pop_front() : 32'h0);
    end
    acc(1'b0, A_RX_DATA, 32'h0);
    chk({31'h0, refused}, 32'h1);
    acc(1'b1, A_RX_CFG, 32'h0);
    pkt(6);
    acc(1'b1, A_RX_DP, 32'h8000_0000);
    for (k = 0; k < 200 && bus.rx_skip_busy; k++) @(posedge sys_clk_i);
    lim();
    rc(A_RX_INF, 32'h0001_0000);
    rc(A_RX_STAT, 32'h0018_0000);
    pkt(2);
    acc(1'b1, A_RX_CFG, 32'h8000);
    repeat (2) @(posedge sys_clk_i);
    rc(A_RX_INF, 32'h0);
    $display("test rx done");
    acc(1'b1, A_TX_CFG, 32'h1);
    acc(1'b1, A_TX_DATA, 32'h0104_3004);
    acc(1'b1, A_TX_DATA, 32'h5a5a_0004);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wd[i] = seed;
      acc(1'b1, A_TX_DATA, seed);
    end
    for (k = 0; k < 200 && tx_n < 3; k++) @(posedge sys_clk_i);
    lim();
    repeat (8) @(posedge sys_clk_i);
    chk(32'(tx_n), 32'h3);
    chk(tx_last, wd[1]);
    tx_stat_i <= wd[0];
    tx_stat_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    tx_stat_valid_i <= 1'b0;
    acc(1'b1, A_TX_CFG, 32'h3);
    repeat (4) @(posedge sys_clk_i);
    rc(A_INTERRUPT_STATUS_REG, 32'h4);
    rc(A_TX_CFG, 32'h0);
    // Packet length 8 in command B against 4 bytes sent
    acc(1'b1, A_INTERRUPT_STATUS_REG, 32'h4);
    acc(1'b1, A_TX_CFG, 32'h1);
    acc(1'b1, A_TX_DATA, 32'h0000_3004);
    acc(1'b1, A_TX_DATA, 32'h0000_0008);
    acc(1'b1, A_TX_DATA, 32'hc3c3_0001);
    for (k = 0; k < 200 && tx_n < 6; k++) @(posedge sys_clk_i);
    lim();
    chk(32'(tx_n), 32'h6);
    rc(A_INTERRUPT_STATUS_REG, 32'h1);
    $display("test tx done");
    finish_test();
  end
endmodule // host_packet_fifo_datapath_bench
`default_nettype wire
